//--- rtl/prescaled_pwm_channel.sv
`timescale 1ns/100ps
module prescaled_pwm_channel (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [5:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic pwm_out,
  output logic irq_out
);
  logic [2:0] coarse_div_exponent;
  logic [4:0] fine_div_value;
  logic run_enable_bit;
  logic output_invert_bit;
  logic period_match_flag;
  logic interrupt_mask_bit;
  logic [15:0] duty_preload;
  logic [15:0] period_preload;
  logic [15:0] duty_eff;
  logic [15:0] period_eff;
  logic [15:0] counter;
  logic run_d;
  logic start;
  logic coarse_tick;
  logic tick_clock;
  logic end_count;
  logic match_event;
  logic next_level;

  function automatic logic hit(input logic [5:0] a);
    hit = wr_in && (addr_in == a);
  endfunction

  assign start = run_enable_bit && !run_d;
  assign end_count = tick_clock && (counter == period_eff);
  assign match_event = start || end_count;

  coarse_divider u_coarse (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .run_in(run_enable_bit),
    .exp_in(coarse_div_exponent),
    .tick_out(coarse_tick)
  );

  fine_divider u_fine (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .run_in(run_enable_bit),
    .step_in(coarse_tick),
    .value_in(fine_div_value),
    .tick_out(tick_clock)
  );

  // ==========================================================
  // configuration registers
  // reserved bits dropped
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      coarse_div_exponent <= 3'h0;
      fine_div_value <= 5'h00;
      run_enable_bit <= 1'b0;
      output_invert_bit <= 1'b0;
      interrupt_mask_bit <= 1'b0;
      duty_preload <= pwm_pkg::RESET_VAL;
      period_preload <= pwm_pkg::RESET_VAL;
    end else if (ce_in) begin
      if (hit(pwm_pkg::ADDR_COARSE)) begin
        coarse_div_exponent <= wdata_in[2:0];
      end
      if (hit(pwm_pkg::ADDR_FINE)) begin
        fine_div_value <= wdata_in[4:0];
      end
      if (hit(pwm_pkg::ADDR_ENABLE)) begin
        run_enable_bit <= wdata_in[pwm_pkg::BIT0];
      end
      if (hit(pwm_pkg::ADDR_POLARITY)) begin
        output_invert_bit <= wdata_in[pwm_pkg::BIT0];
      end
      if (hit(pwm_pkg::ADDR_MASK)) begin
        interrupt_mask_bit <= wdata_in[pwm_pkg::BIT0];
      end
      if (hit(pwm_pkg::ADDR_DUTY)) begin
        duty_preload <= wdata_in;
      end
      if (hit(pwm_pkg::ADDR_PERIOD)) begin
        period_preload <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_d <= 1'b0;
    end else if (ce_in) begin
      run_d <= run_enable_bit;
    end
  end

  // ==========================================================
  // effective registers
  // reset values
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      duty_eff <= pwm_pkg::RESET_VAL;
      period_eff <= pwm_pkg::RESET_VAL;
    end else if (ce_in) begin
      if (!run_enable_bit) begin
        duty_eff <= pwm_pkg::RESET_VAL;
      end else if (start || end_count) begin
        duty_eff <= duty_preload;
        period_eff <= period_preload;
      end
    end
  end

  // ==========================================================
  // counter
  // tick stepped count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter <= pwm_pkg::RESET_VAL;
    end else if (ce_in) begin
      if (!run_enable_bit || start) begin
        counter <= pwm_pkg::RESET_VAL;
      end else if (end_count) begin
        counter <= pwm_pkg::RESET_VAL;
      end else if (tick_clock) begin
        counter <= counter + pwm_pkg::CNT_ONE;
      end
    end
  end

  // ==========================================================
  // output level
  // compare
  always_comb begin
    next_level = run_enable_bit && (counter < duty_eff);
    next_level = next_level ^ output_invert_bit;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwm_out <= 1'b0;
    end else if (ce_in) begin
      pwm_out <= next_level;
    end
  end

  // ==========================================================
  // period match flag and request
  // set beats clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      period_match_flag <= 1'b0;
    end else if (ce_in) begin
      if (match_event) begin
        period_match_flag <= 1'b1;
      end else if (hit(pwm_pkg::ADDR_FLAG) && !wdata_in[pwm_pkg::BIT0]) begin
        period_match_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= interrupt_mask_bit &&
        (period_match_flag || match_event);
    end
  end

  // ==========================================================
  // read port
  // reserved read zero
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= pwm_pkg::RESET_VAL;
    end else if (ce_in) begin
      rdata_out <= pwm_pkg::RESET_VAL;
      if (rd_in) begin
        case (addr_in)
          pwm_pkg::ADDR_COARSE: rdata_out <= {13'h0000, coarse_div_exponent};
          pwm_pkg::ADDR_FINE: rdata_out <= {11'h000, fine_div_value};
          pwm_pkg::ADDR_ENABLE: rdata_out <= {15'h0000, run_enable_bit};
          pwm_pkg::ADDR_POLARITY: rdata_out <= {15'h0000, output_invert_bit};
          pwm_pkg::ADDR_FLAG: rdata_out <= {15'h0000, period_match_flag};
          pwm_pkg::ADDR_MASK: rdata_out <= {15'h0000, interrupt_mask_bit};
          pwm_pkg::ADDR_DUTY: rdata_out <= duty_preload;
          pwm_pkg::ADDR_PERIOD: rdata_out <= period_preload;
          default: rdata_out <= pwm_pkg::RESET_VAL;
        endcase
      end
    end
  end

  // ==========================================================
  // check helpers
  // enabled cycles since the last tick; trusted only after a tick
  // under the prescaler setting now in force
  logic [15:0] tick_span;
  logic [15:0] tick_gap;
  logic gap_valid;

  assign tick_span =
    ({11'h000, fine_div_value} + pwm_pkg::CNT_ONE) << coarse_div_exponent;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_gap <= pwm_pkg::RESET_VAL;
    end else if (ce_in) begin
      if (!run_enable_bit || tick_clock) begin
        tick_gap <= pwm_pkg::RESET_VAL;
      end else begin
        tick_gap <= tick_gap + pwm_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gap_valid <= 1'b0;
    end else if (ce_in) begin
      if (!run_enable_bit || hit(pwm_pkg::ADDR_COARSE)
          || hit(pwm_pkg::ADDR_FINE)) begin
        gap_valid <= 1'b0;
      end else if (tick_clock) begin
        gap_valid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  flag_set_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && end_count |=> period_match_flag)
    else $error("flag not set at end of count");

  disable_low_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !run_enable_bit && !output_invert_bit |=> !pwm_out)
    else $error("output not low while disabled");

  counter_clear_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !run_enable_bit |=> counter == pwm_pkg::RESET_VAL)
    else $error("counter not cleared");

  restart_zero_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && run_enable_bit && run_d && end_count
      |=> counter == pwm_pkg::RESET_VAL)
    else $error("counter did not restart");

  irq_masked_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !interrupt_mask_bit |=> !irq_out || $past(interrupt_mask_bit))
    else $error("request passed while masked");

  start_flag_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && start |=> period_match_flag)
    else $error("no request at start");

  start_load_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && start |=> period_eff == $past(period_preload))
    else $error("period not loaded at start");

  high_below_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && run_enable_bit && counter < duty_eff
      |=> pwm_out == !$past(output_invert_bit))
    else $error("output wrong below duty");

  flag_hold_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && period_match_flag && !(wr_in && addr_in == pwm_pkg::ADDR_FLAG)
      |=> period_match_flag)
    else $error("flag lost without clear");

  tick_span_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && tick_clock && gap_valid
      |-> tick_gap == tick_span - pwm_pkg::CNT_ONE)
    else $error("tick spacing differs from prescaler setting");

  count_step_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && run_enable_bit && run_d && tick_clock && !end_count
      |=> counter == $past(counter) + pwm_pkg::CNT_ONE)
    else $error("counter did not step on tick");

  count_hold_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && run_enable_bit && run_d && !tick_clock |=> $stable(counter))
    else $error("counter moved without tick");

  period_reload_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && run_enable_bit && run_d && end_count
      |=> duty_eff == $past(duty_preload)
        && period_eff == $past(period_preload))
    else $error("effective registers not reloaded");

  duty_clear_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !run_enable_bit |=> duty_eff == pwm_pkg::RESET_VAL)
    else $error("duty not cleared while disabled");

  low_at_duty_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && run_enable_bit && counter >= duty_eff
      |=> pwm_out == $past(output_invert_bit))
    else $error("output wrong at or above duty");

  disabled_level_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !run_enable_bit |=> pwm_out == $past(output_invert_bit))
    else $error("disabled level ignores polarity");

  irq_follow_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && interrupt_mask_bit && period_match_flag |=> irq_out)
    else $error("request not passed while unmasked");

  read_idle_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && !rd_in |=> rdata_out == pwm_pkg::RESET_VAL)
    else $error("read data stand beyond one cycle");

  reserved_read_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && rd_in && addr_in != pwm_pkg::ADDR_DUTY
      && addr_in != pwm_pkg::ADDR_PERIOD
      |=> rdata_out[pwm_pkg::DATA_W-1:pwm_pkg::FINE_W] == '0)
    else $error("reserved bits read nonzero");

  freeze_hold_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    !ce_in |=> $stable(counter) && $stable(pwm_out)
      && $stable(period_match_flag) && $stable(irq_out)
      && $stable(rdata_out))
    else $error("state moved while clock enable low");
endmodule // prescaled_pwm_channel

//--- rtl/pwm_pkg.sv
// Behaviour
// - coarse stage divides by two to exponent
// - fine stage divides by value plus one
// - reset clears counter and duty, output low
// - enable loads preloads and starts counting
// - enable raises period match request
// - output high while counter below duty
// - period end reloads, flags, restarts counter
// - disable clears counter and duty, output goes to invert bit level
// - invert bit flips output level
// - duty above period keeps output high
// - period is value plus one ticks
// - duty counts high ticks
// - zero period gives one tick period
// - full high at max period needs inversion
// - hardware sets flag, software clears it
// - mask bit gates interrupt request
// - request at every end of count
// - reserved bits read zero, ignore writes
// - split preload update transfers written value
package pwm_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int EXP_W = 3;
  localparam int FINE_W = 5;
  localparam int COARSE_CNT_W = 7;
  localparam logic [5:0] ADDR_COARSE = 6'h00;
  localparam logic [5:0] ADDR_FINE = 6'h04;
  localparam logic [5:0] ADDR_ENABLE = 6'h08;
  localparam logic [5:0] ADDR_POLARITY = 6'h0C;
  localparam logic [5:0] ADDR_FLAG = 6'h10;
  localparam logic [5:0] ADDR_MASK = 6'h14;
  localparam logic [5:0] ADDR_DUTY = 6'h1C;
  localparam logic [5:0] ADDR_PERIOD = 6'h20;
  localparam int BIT0 = 0;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [6:0] PRE_ONE = 7'h01;
  localparam logic [4:0] FINE_ONE = 5'h01;
endpackage

//--- rtl/coarse_divider.sv
`timescale 1ns/100ps
// first stage: one pulse every 2**exponent enabled cycles
module coarse_divider (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic [2:0] exp_in,
  output logic tick_out
);
  logic [6:0] count;
  logic [6:0] limit;

  assign limit = 7'((8'h01 << exp_in) - 8'h01);

  // ==========================================================
  // coarse count
  // power of two
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= 7'h00;
    end else if (ce_in) begin
      if (!run_in || count >= limit) begin
        count <= 7'h00;
      end else begin
        count <= count + pwm_pkg::PRE_ONE;
      end
    end
  end

  assign tick_out = run_in && (count >= limit);
endmodule // coarse_divider

//--- rtl/fine_divider.sv
`timescale 1ns/100ps
// second stage: one tick every value+1 coarse pulses
module fine_divider (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic run_in,
  input wire logic step_in,
  input wire logic [4:0] value_in,
  output logic tick_out
);
  logic [4:0] count;

  // ==========================================================
  // fine count
  // value plus one
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= 5'h00;
    end else if (ce_in) begin
      if (!run_in) begin
        count <= 5'h00;
      end else if (step_in) begin
        if (count >= value_in) begin
          count <= 5'h00;
        end else begin
          count <= count + pwm_pkg::FINE_ONE;
        end
      end
    end
  end

  assign tick_out = step_in && (count >= value_in);
endmodule // fine_divider

//--- testbench/pwm_load_model.sv
`timescale 1ns/100ps
// load on the pwm pin: integrates the cycles it sees the pin high
module pwm_load_model (
  input wire logic clk_in,
  input wire logic pwm_in,
  input wire logic clr_in,
  output logic [15:0] high_cnt_out
);
  // =====================================================
  // high time integrator
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      high_cnt_out <= 16'h0000;
    end else begin
      high_cnt_out <= high_cnt_out + {15'h0000, pwm_in};
    end
  end
endmodule // pwm_load_model

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk_in;
  logic nrst_in;
  logic [5:0] addr_in;
  logic [15:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [15:0] rdata_out;
  logic pwm_out;
  logic irq_out;
  logic clr;
  logic ce;
  logic [15:0] high_cnt;
  logic [15:0] d;
  int fail_count;
  int num_checks;

  prescaled_pwm_channel i_prescaled_pwm_channel (.clk_in(clk_in),
    .nrst_in(nrst_in), .ce_in(ce), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pwm_out(pwm_out), .irq_out(irq_out));
  pwm_load_model i_pwm_load_model (.clk_in(clk_in), .pwm_in(pwm_out),
    .clr_in(clr), .high_cnt_out(high_cnt));

  // =====================================================
  // clock, verdict and shared tasks
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  task automatic measure(input int n, input logic [15:0] exp);
    repeat (16) @(posedge clk_in);
    clr <= 1'b1;
    @(posedge clk_in);
    clr <= 1'b0;
    repeat (n) @(posedge clk_in);
    #1 chk(high_cnt, exp);
  endtask

  // =====================================================
  // scenarios
  task automatic regs_after_reset();
    for (int i = 0; i < 9; i++) begin
      rd(6'(i * 4), d);
      chk(d, 16'h0000);
    end
    wr(pwm_pkg::ADDR_COARSE, 16'hFFFF);
    rd(pwm_pkg::ADDR_COARSE, d);
    chk(d, 16'h0007);
    wr(pwm_pkg::ADDR_FINE, 16'hFFFF);
    rd(pwm_pkg::ADDR_FINE, d);
    chk(d, 16'h001F);
    wr(pwm_pkg::ADDR_POLARITY, 16'hFFFE);
    rd(pwm_pkg::ADDR_POLARITY, d);
    chk(d, 16'h0000);
    wr(6'h18, 16'hFFFF);
    rd(6'h18, d);
    chk(d, 16'h0000);
    wr(pwm_pkg::ADDR_COARSE, 16'h0000);
    wr(pwm_pkg::ADDR_FINE, 16'h0000);
  endtask

  task automatic enable_event_max_period();
    wr(pwm_pkg::ADDR_PERIOD, 16'hFFFF);
    wr(pwm_pkg::ADDR_MASK, 16'h0001);
    wr(pwm_pkg::ADDR_POLARITY, 16'h0001);
    wr(pwm_pkg::ADDR_ENABLE, 16'h0001);
    repeat (3) @(posedge clk_in);
    #1 chk({15'h0000, irq_out}, 16'h0001);
    rd(pwm_pkg::ADDR_FLAG, d);
    chk(d, 16'h0001);
    measure(40, 16'h0028);
    wr(pwm_pkg::ADDR_FLAG, 16'h0001);
    rd(pwm_pkg::ADDR_FLAG, d);
    chk(d, 16'h0001);
    wr(pwm_pkg::ADDR_FLAG, 16'h0000);
    rd(pwm_pkg::ADDR_FLAG, d);
    chk(d, 16'h0000);
    chk({15'h0000, irq_out}, 16'h0000);
    wr(pwm_pkg::ADDR_ENABLE, 16'h0000);
    wr(pwm_pkg::ADDR_POLARITY, 16'h0000);
  endtask

  task automatic waveforms();
    wr(pwm_pkg::ADDR_PERIOD, 16'h0003);
    wr(pwm_pkg::ADDR_DUTY, 16'h0001);
    wr(pwm_pkg::ADDR_ENABLE, 16'h0001);
    measure(40, 16'h000A);
    wr(pwm_pkg::ADDR_FLAG, 16'h0000);
    repeat (8) @(posedge clk_in);
    #1 chk({15'h0000, irq_out}, 16'h0001);
    wr(pwm_pkg::ADDR_MASK, 16'h0000);
    repeat (2) @(posedge clk_in);
    #1 chk({15'h0000, irq_out}, 16'h0000);
    wr(pwm_pkg::ADDR_POLARITY, 16'h0001);
    measure(40, 16'h001E);
    wr(pwm_pkg::ADDR_POLARITY, 16'h0000);
    wr(pwm_pkg::ADDR_DUTY, 16'h0005);
    measure(40, 16'h0028);
    wr(pwm_pkg::ADDR_FLAG, 16'h0000);
    repeat (8) @(posedge clk_in);
    rd(pwm_pkg::ADDR_FLAG, d);
    chk(d, 16'h0001);
    wr(pwm_pkg::ADDR_PERIOD, 16'h0000);
    wr(pwm_pkg::ADDR_DUTY, 16'h0000);
    measure(40, 16'h0000);
    wr(pwm_pkg::ADDR_DUTY, 16'h0001);
    measure(40, 16'h0028);
    wr(pwm_pkg::ADDR_ENABLE, 16'h0000);
    measure(20, 16'h0000);
  endtask

  task automatic prescaled();
    wr(pwm_pkg::ADDR_COARSE, 16'h0001);
    wr(pwm_pkg::ADDR_FINE, 16'h0002);
    wr(pwm_pkg::ADDR_PERIOD, 16'h0001);
    wr(pwm_pkg::ADDR_DUTY, 16'h0001);
    wr(pwm_pkg::ADDR_ENABLE, 16'h0001);
    measure(48, 16'h0018);
    wr(pwm_pkg::ADDR_FINE, 16'h0000);
    measure(48, 16'h0018);
  endtask

  // clock enable low: output holds and a write is ignored
  task automatic clock_enable_freeze();
    logic level;
    @(posedge clk_in);
    ce <= 1'b0;
    @(posedge clk_in);
    #1 level = pwm_out;
    wr(pwm_pkg::ADDR_MASK, 16'h0001);
    repeat (8) @(posedge clk_in);
    #1 chk({15'h0000, pwm_out}, {15'h0000, level});
    @(posedge clk_in);
    ce <= 1'b1;
    rd(pwm_pkg::ADDR_MASK, d);
    chk(d, 16'h0000);
  endtask

  // second reset while the output is held high
  task automatic reset_mid_run();
    wr(pwm_pkg::ADDR_DUTY, 16'h0005);
    repeat (8) @(posedge clk_in);
    #1 chk({15'h0000, pwm_out}, 16'h0001);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk({15'h0000, pwm_out}, 16'h0000);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(pwm_pkg::ADDR_ENABLE, d);
    chk(d, 16'h0000);
    measure(20, 16'h0000);
  endtask

  // =====================================================
  // main sequence and watchdog
  initial begin
    fail_count = 0;
    num_checks = 0;
    nrst_in = 1'b0;
    addr_in = 6'h00;
    wdata_in = 16'h0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    clr = 1'b1;
    ce = 1'b1;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    regs_after_reset();
    enable_event_max_period();
    waveforms();
    prescaled();
    clock_enable_freeze();
    reset_mid_run();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    stop_test();
  end
endmodule // testbench
